// File: src/dss_defs.vh
// Constants for the DAC sequencer status block: offsets, bit positions, widths.
// Included by every design file of the block; definitions only.
`ifndef DSS_DEFS_VH
`define DSS_DEFS_VH
`define DSS_OFF_STATUS 12'h2EC
`define DSS_OFF_INT_STAT 12'h2F0
`define DSS_OFF_INT_MASK 12'h300
`define DSS_BIT_DMA_DONE 20
`define DSS_BIT_DMA_ERR 18
`define DSS_BIT_DMA_BSY 17
`define DSS_BIT_DMA_IDLE 16
`define DSS_BIT_FRM_ERR 6
`define DSS_BIT_TIME_ERR 5
`define DSS_BIT_DATA_ERR 4
`define DSS_BIT_CNV_ACT 2
`define DSS_BIT_PRLD 1
`define DSS_BIT_OU_IDLE 0
`define DSS_CNT_W 28
`define DSS_CNT_ZERO 28'h0000000
`define DSS_CNT_ONE 28'h0000001
`define DSS_WORD_ZERO 32'h00000000
`define DSS_INT_W 5
`define DSS_INT_ZERO 5'h00
`define DSS_ADDR_W 12
`endif

// File: src/dss_dma_state.v
// DMA engine state tracker: idle, busy, error and buffer-done flags.
// Assumes single-cycle event pulses from the DMA engine, all on CLK.
`include "dss_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module dss_dma_state (
  input wire clk, // Clock
  input wire reset, // Sync reset, high
  input wire dma_enable, // DMA engine enabled
  input wire len_write, // Buffer-length register write
  input wire fetch_last, // Last buffer value fetched
  input wire pci_abort, // Master or target abort
  output reg dma_buffer_done_q, // Buffer done
  output reg dma_error_state_q, // Error state
  output reg dma_busy_state_q, // Busy state
  output wire dma_idle_state // Idle state
);
  assign dma_idle_state = ~dma_busy_state_q & ~dma_error_state_q;
  always @(posedge clk) begin
    if (reset) begin
      dma_buffer_done_q <= 1'b0;
      dma_error_state_q <= 1'b0;
      dma_busy_state_q <= 1'b0;
    end else begin
      if (!dma_enable) begin
        dma_error_state_q <= 1'b0;
      end else if (dma_busy_state_q && pci_abort) begin
        dma_error_state_q <= 1'b1;
      end
      if (!dma_enable || pci_abort || fetch_last) begin
        dma_busy_state_q <= 1'b0;
      end else if (len_write && dma_idle_state) begin
        dma_busy_state_q <= 1'b1;
      end
      if (dma_busy_state_q && fetch_last && !pci_abort && dma_enable) begin
        dma_buffer_done_q <= 1'b1;
      end else if (len_write && dma_idle_state && dma_enable) begin
        dma_buffer_done_q <= 1'b0;
      end
    end
  end
endmodule // dss_dma_state
`default_nettype wire

// File: src/dss_output_unit.v
// Output unit state: conversion run, error flags, pre-load and idle.
// Assumes conversion pulses and frame triggers are single cycles on CLK.
`include "dss_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module dss_output_unit #(
  parameter CNT_W = `DSS_CNT_W
) (
  input wire clk, // Clock
  input wire reset, // Sync reset, high
  input wire ou_enable, // Output unit enabled
  input wire frame_mode, // 1 frame mode, 0 normal
  input wire conv_start, // Software start, normal mode
  input wire frame_trig, // Frame trigger event
  input wire conv_due, // Conversion pulse due
  input wire timing_bad, // Pulse would break DAC timing
  input wire all_loaded, // All DACs hold all four channels
  input wire clear_preload, // Manual pre-load clear
  input wire [CNT_W-1:0] num_conv, // Configured conversion count
  output reg frame_err_q, // Frame error
  output reg time_err_q, // Timing error
  output reg data_err_q, // Data error
  output reg conv_act_q, // Conversion active
  output reg preload_q, // DACs pre-loaded
  output wire ou_idle, // Output unit idle
  output wire conv_pulse // Conversion pulse issued
);
  reg [CNT_W-1:0] done_cnt_q;
  wire stopped = frame_err_q | time_err_q | data_err_q;
  wire continuous = (num_conv == {CNT_W{1'b0}});
  wire run_go = conv_act_q & conv_due & ~stopped;
  wire bad_time = run_go & timing_bad;
  wire bad_data = run_go & ~timing_bad & ~preload_q;
  wire last_conv = (done_cnt_q == num_conv - {{(CNT_W-1){1'b0}}, 1'b1});
  wire frm_err_ev = ou_enable & frame_mode & frame_trig & conv_act_q & ~continuous & ~stopped;
  wire start_ev = ou_enable & ~stopped & ~frm_err_ev &
                  (frame_mode ? frame_trig : conv_start);
  assign conv_pulse = run_go & ~timing_bad & preload_q & ~frm_err_ev;
  assign ou_idle = ~conv_act_q & ~stopped;
  always @(posedge clk) begin
    if (reset || !ou_enable) begin
      frame_err_q <= 1'b0;
      time_err_q <= 1'b0;
      data_err_q <= 1'b0;
      conv_act_q <= 1'b0;
      done_cnt_q <= {CNT_W{1'b0}};
    end else begin
      if (frm_err_ev) begin
        frame_err_q <= 1'b1;
      end
      if (bad_time) begin
        time_err_q <= 1'b1;
      end
      if (bad_data) begin
        data_err_q <= 1'b1;
      end
      if (frm_err_ev || bad_time || bad_data) begin
        conv_act_q <= 1'b0;
      end else if (start_ev) begin
        conv_act_q <= 1'b1;
        done_cnt_q <= {CNT_W{1'b0}};
      end else if (conv_pulse) begin
        done_cnt_q <= done_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        if (!continuous && last_conv) begin
          conv_act_q <= 1'b0;
        end
      end
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      preload_q <= 1'b0;
    end else if (conv_pulse || clear_preload || !ou_enable) begin
      preload_q <= 1'b0;
    end else begin
      preload_q <= all_loaded;
    end
  end
endmodule // dss_output_unit
`default_nettype wire

// File: src/dss_top.v
// DAC sequencer status block: status word, event interrupt, APB slave.
// Assumes all event inputs come from logic on CLK; APB master on CLK.
//
// Implementation choice: the APB interface to the registers.
`include "dss_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module dss_top #(
  parameter CNT_W = `DSS_CNT_W
) (
  input wire CLK, // Clock, 25 MHz
  input wire RESET, // Sync reset, high
  input wire PSEL, // APB select
  input wire PENABLE, // APB enable
  input wire PWRITE, // APB direction
  input wire [`DSS_ADDR_W-1:0] PADDR, // APB byte address
  input wire [31:0] PWDATA, // APB write data
  output wire PREADY, // APB ready
  output reg [31:0] PRDATA, // APB read data
  output wire PSLVERR, // APB error
  output wire IRQ, // Interrupt, level high
  input wire DMA_ENABLE, // DMA engine enabled
  input wire LEN_WRITE, // Buffer-length register write
  input wire FETCH_LAST, // Last buffer value fetched
  input wire PCI_ABORT, // Master or target abort
  input wire OU_ENABLE, // Output unit enabled
  input wire FRAME_MODE, // Frame mode select
  input wire CONV_START, // Software start
  input wire FRAME_TRIG, // Frame trigger
  input wire CONV_DUE, // Conversion pulse due
  input wire TIMING_BAD, // Timing limit would break
  input wire ALL_LOADED, // All DACs loaded
  input wire CLEAR_PRELOAD, // Manual pre-load clear
  input wire [CNT_W-1:0] NUM_CONV, // Conversion count
  output wire CONV_PULSE, // Conversion pulse to DACs
  output wire [31:0] STATUS // Status word
);
  wire dma_buffer_done;
  wire dma_error_state;
  wire dma_busy_state;
  wire dma_idle_state;
  wire output_frame_error;
  wire output_timing_error;
  wire output_data_error;
  wire conversion_active;
  wire dacs_preloaded;
  wire output_unit_idle;
  reg [`DSS_INT_W-1:0] int_stat_q;
  reg [`DSS_INT_W-1:0] int_mask_q;
  reg [`DSS_INT_W-1:0] int_stat_d;
  reg [`DSS_INT_W-1:0] prev_q;
  reg [31:0] status_w;
  reg [31:0] rdata_d;
  wire [`DSS_INT_W-1:0] rise_ev;
  wire apb_access = PSEL & PENABLE;
  wire apb_wr = apb_access & PWRITE;
  wire hit_status = (PADDR == `DSS_OFF_STATUS);
  wire hit_stat = (PADDR == `DSS_OFF_INT_STAT);
  wire hit_mask = (PADDR == `DSS_OFF_INT_MASK);
  wire mapped = hit_status | hit_stat | hit_mask;

  dss_dma_state u_dma (
    .clk(CLK),
    .reset(RESET),
    .dma_enable(DMA_ENABLE),
    .len_write(LEN_WRITE),
    .fetch_last(FETCH_LAST),
    .pci_abort(PCI_ABORT),
    .dma_buffer_done_q(dma_buffer_done),
    .dma_error_state_q(dma_error_state),
    .dma_busy_state_q(dma_busy_state),
    .dma_idle_state(dma_idle_state)
  );

  dss_output_unit #(.CNT_W(CNT_W)) u_ou (
    .clk(CLK),
    .reset(RESET),
    .ou_enable(OU_ENABLE),
    .frame_mode(FRAME_MODE),
    .conv_start(CONV_START),
    .frame_trig(FRAME_TRIG),
    .conv_due(CONV_DUE),
    .timing_bad(TIMING_BAD),
    .all_loaded(ALL_LOADED),
    .clear_preload(CLEAR_PRELOAD),
    .num_conv(NUM_CONV),
    .frame_err_q(output_frame_error),
    .time_err_q(output_timing_error),
    .data_err_q(output_data_error),
    .conv_act_q(conversion_active),
    .preload_q(dacs_preloaded),
    .ou_idle(output_unit_idle),
    .conv_pulse(CONV_PULSE)
  );

  always @* begin
    status_w = `DSS_WORD_ZERO;
    status_w[`DSS_BIT_DMA_DONE] = dma_buffer_done;
    status_w[`DSS_BIT_DMA_ERR] = dma_error_state;
    status_w[`DSS_BIT_DMA_BSY] = dma_busy_state;
    status_w[`DSS_BIT_DMA_IDLE] = dma_idle_state;
    status_w[`DSS_BIT_FRM_ERR] = output_frame_error;
    status_w[`DSS_BIT_TIME_ERR] = output_timing_error;
    status_w[`DSS_BIT_DATA_ERR] = output_data_error;
    status_w[`DSS_BIT_CNV_ACT] = conversion_active;
    status_w[`DSS_BIT_PRLD] = dacs_preloaded;
    status_w[`DSS_BIT_OU_IDLE] = output_unit_idle;
  end
  assign STATUS = status_w;

  // Events are the rising edges of DMA done, DMA error and the three output errors
  wire [`DSS_INT_W-1:0] ev_src = {dma_buffer_done, dma_error_state, output_frame_error,
                                  output_timing_error, output_data_error};
  genvar gi;
  generate
    for (gi = 0; gi < `DSS_INT_W; gi = gi + 1) begin : g_ev
      assign rise_ev[gi] = ev_src[gi] & ~prev_q[gi];
    end
  endgenerate

  // Write-one-to-clear; a new event in the same cycle keeps its bit set
  always @* begin
    int_stat_d = int_stat_q;
    if (apb_wr && hit_stat) begin
      int_stat_d = int_stat_q & ~PWDATA[`DSS_INT_W-1:0];
    end
    int_stat_d = int_stat_d | rise_ev;
  end

  always @(posedge CLK) begin
    if (RESET) begin
      int_stat_q <= `DSS_INT_ZERO;
      int_mask_q <= `DSS_INT_ZERO;
      prev_q <= `DSS_INT_ZERO;
    end else begin
      int_stat_q <= int_stat_d;
      prev_q <= ev_src;
      if (apb_wr && hit_mask) begin
        int_mask_q <= PWDATA[`DSS_INT_W-1:0];
      end
    end
  end
  assign IRQ = |(int_stat_q & int_mask_q);

  // Read data registered in the setup cycle so the access phase needs no wait
  always @* begin
    rdata_d = `DSS_WORD_ZERO;
    if (hit_status) begin
      rdata_d = status_w;
    end else if (hit_stat) begin
      rdata_d[`DSS_INT_W-1:0] = int_stat_q;
    end else if (hit_mask) begin
      rdata_d[`DSS_INT_W-1:0] = int_mask_q;
    end
  end
  always @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= `DSS_WORD_ZERO;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata_d;
    end
  end
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access & ~mapped;
endmodule // dss_top
`default_nettype wire

// File: verif/dss_peer.sv
// DMA target model: answers a busy engine after a set lag.
// Assumes busy is taken from the status word on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dss_peer (
  input wire logic clk, // Clock
  input wire logic busy, // Engine transferring
  input wire logic fail, // Answer with an abort
  input wire logic [3:0] lag, // Cycles before answer
  output logic last, // Last value fetched
  output logic abort // Master or target abort
);
  logic [3:0] cnt_q = '0;
  initial begin
    last = '0;
    abort = '0;
  end
  always @(posedge clk) begin
    last <= '0;
    abort <= '0;
    cnt_q <= '0;
    if (busy && !last && !abort) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == lag) begin
        last <= !fail;
        abort <= fail;
      end
    end
  end
endmodule // dss_peer
`default_nettype wire

// File: verif/dss_chk_sva.sv
// Port assertions for the status block.
// Assumes one clock CLK and a sync reset RESET.
`timescale 1ns/1ps
`default_nettype none
module dss_chk #(
  parameter CNT_W = 28
) (
  input wire logic CLK, // Clock
  input wire logic RESET, // Sync reset
  input wire logic DMA_ENABLE, // DMA enable
  input wire logic LEN_WRITE, // Length write
  input wire logic FETCH_LAST, // Last fetched
  input wire logic PCI_ABORT, // Abort
  input wire logic OU_ENABLE, // Output enable
  input wire logic FRAME_MODE, // Frame mode
  input wire logic FRAME_TRIG, // Frame trigger
  input wire logic CONV_DUE, // Pulse due
  input wire logic TIMING_BAD, // Timing bad
  input wire logic ALL_LOADED, // DACs loaded
  input wire logic [CNT_W-1:0] NUM_CONV, // Count
  input wire logic CONV_PULSE, // Pulse out
  input wire logic [31:0] STATUS // Status word
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  a_busy_start: assert property (LEN_WRITE && STATUS[16] && DMA_ENABLE |=> STATUS[17] && !STATUS[20])
    else $error("busy did not start");
  a_done_set: assert property (FETCH_LAST && STATUS[17] && DMA_ENABLE |=> STATUS[20] && !STATUS[17])
    else $error("done not set");
  a_abort_err: assert property (PCI_ABORT && STATUS[17] && DMA_ENABLE |=> STATUS[18] && !STATUS[17])
    else $error("abort not flagged");
  a_dma_off: assert property (!DMA_ENABLE |=> !STATUS[18] && !STATUS[17])
    else $error("dma error kept");
  a_dma_idle: assert property (STATUS[16] == (!STATUS[17] && !STATUS[18]))
    else $error("dma idle wrong");
  a_time_err: assert property (CONV_DUE && TIMING_BAD && STATUS[2] && OU_ENABLE |=> STATUS[5] && !STATUS[2])
    else $error("timing error missed");
  a_data_err: assert property (CONV_DUE && !TIMING_BAD && !STATUS[1] && STATUS[2] && OU_ENABLE |=> STATUS[4])
    else $error("data error missed");
  a_pulse_ok: assert property (CONV_PULSE |-> (STATUS[2] && STATUS[1] && !TIMING_BAD) ##1 !STATUS[1])
    else $error("bad conversion pulse");
  a_prld_src: assert property (STATUS[1] |-> $past(ALL_LOADED))
    else $error("preload without data");
  a_frame_err: assert property (FRAME_TRIG && FRAME_MODE && STATUS[2] && OU_ENABLE && NUM_CONV != 0 |=> STATUS[6])
    else $error("frame error missed");
  a_cont_run: assert property (NUM_CONV == 0 && STATUS[2] && OU_ENABLE && !CONV_DUE |=> STATUS[2])
    else $error("continuous run stopped");
  a_err_hold: assert property (STATUS[6:4] != 0 && OU_ENABLE |=> $stable(STATUS[6:4]))
    else $error("error flag lost");
  a_ou_off: assert property (!OU_ENABLE |=> STATUS[6:4] == 0 && !STATUS[2])
    else $error("disable left state");
  a_ou_idle: assert property (STATUS[0] == (!STATUS[2] && STATUS[6:4] == 0))
    else $error("idle flag wrong");
  a_rsvd_zero: assert property ((STATUS & 32'hFFE8FF88) == 0)
    else $error("reserved bit set");
endmodule // dss_chk
bind dss_top dss_chk #(.CNT_W(CNT_W)) u_chk (.CLK(CLK), .RESET(RESET), .DMA_ENABLE(DMA_ENABLE),
  .LEN_WRITE(LEN_WRITE), .FETCH_LAST(FETCH_LAST), .PCI_ABORT(PCI_ABORT), .OU_ENABLE(OU_ENABLE),
  .FRAME_MODE(FRAME_MODE), .FRAME_TRIG(FRAME_TRIG), .CONV_DUE(CONV_DUE), .TIMING_BAD(TIMING_BAD),
  .ALL_LOADED(ALL_LOADED), .NUM_CONV(NUM_CONV), .CONV_PULSE(CONV_PULSE), .STATUS(STATUS));
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the status block.
// Assumes zero-wait APB and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  logic clk = '0;
  logic reset = '1;
  logic psel = '0, penable = '0, pwrite = '0, se, pready, pslverr, irq, cpulse, fl, pa;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, status, rd;
  logic dma_en = '0, ou_en = '0, fmode = '0, tbad = '0, aload = '0, fail = '0;
  logic [4:0] pv = '0;
  logic [27:0] nconv = '0;
  int error_cnt = 0, total_checks = 0;
  int pulses = 0;
  always #20 clk = ~clk;
  // Counted at the edge that the design samples, so a pulse is seen once
  always @(posedge clk) if (cpulse === 1'b1) pulses++;
  dss_top dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq), .DMA_ENABLE(dma_en),
    .LEN_WRITE(pv[0]), .FETCH_LAST(fl), .PCI_ABORT(pa), .OU_ENABLE(ou_en), .FRAME_MODE(fmode),
    .CONV_START(pv[1]), .FRAME_TRIG(pv[2]), .CONV_DUE(pv[3]), .TIMING_BAD(tbad), .ALL_LOADED(aload),
    .CLEAR_PRELOAD(pv[4]), .NUM_CONV(nconv), .CONV_PULSE(cpulse), .STATUS(status));
  dss_peer peer (.clk(clk), .busy(status[17]), .fail(fail), .lag(4'h3), .last(fl), .abort(pa));
  task complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk) penable <= '1;
    // Ready high ends the wait; the watchdog ends it only if ready never comes
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e, input string n);
    apb('0, a, '0);
    `CHK(n, e, rd)
  endtask
  task sts(input logic [31:0] e, input string n);
    #1 `CHK(n, e, status & 32'h00170077)
  endtask
  task pl(input int i);
    @(posedge clk) pv[i] <= '1;
    @(posedge clk) pv <= '0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= '0;
    sts(32'h00010001, "reset");
    rchk(12'h2EC, 32'h00010001, "rd reset");
    apb('1, 12'h2EC, '1);
    rchk(12'h2EC, 32'h00010001, "wr ignored");
    apb('0, 12'h010, '0);
    `CHK("unmapped", 1'h1, se)
    apb('1, 12'h300, 32'h18);
    $display("test regs done");
    @(posedge clk) dma_en <= '1;
    pl(0);
    sts(32'h00020001, "busy");
    repeat (8) @(posedge clk);
    sts(32'h00110001, "done");
    `CHK("irq on", 1'h1, irq)
    @(posedge clk) fail <= '1;
    pl(0);
    sts(32'h00020001, "restart");
    repeat (8) @(posedge clk);
    sts(32'h00040001, "abort");
    rchk(12'h2F0, 32'h18, "int dma");
    apb('1, 12'h2F0, 32'h10);
    apb('1, 12'h300, '0);
    rchk(12'h2F0, 32'h08, "w1c");
    `CHK("irq masked", 1'h0, irq)
    @(posedge clk) dma_en <= '0;
    @(posedge clk);
    sts(32'h00010001, "dma off");
    $display("test dma done");
    @(posedge clk) {aload, ou_en, nconv} <= {2'h3, 28'h2};
    pl(1);
    sts(32'h00010006, "start");
    pl(3);
    sts(32'h00010004, "conv 1");
    pl(3);
    sts(32'h00010001, "count end");
    pl(4);
    sts(32'h00010001, "clr prld");
    @(posedge clk) aload <= '0;
    pl(1);
    pl(3);
    sts(32'h00010010, "data err");
    repeat (3) @(posedge clk);
    sts(32'h00010010, "err hold");
    @(posedge clk) {ou_en, aload, tbad} <= 3'h3;
    @(posedge clk);
    sts(32'h00010001, "ou off");
    @(posedge clk) ou_en <= '1;
    pl(1);
    pl(3);
    sts(32'h00010022, "time err");
    @(posedge clk) {ou_en, tbad, fmode, nconv} <= {3'h1, 28'h3};
    @(posedge clk) ou_en <= '1;
    pl(2);
    sts(32'h00010006, "frame start");
    pl(2);
    sts(32'h00010042, "frame err");
    @(posedge clk) {ou_en, nconv} <= '0;
    @(posedge clk) ou_en <= '1;
    pl(2);
    pl(3);
    pl(2);
    sts(32'h00010006, "continuous");
    rchk(12'h2F0, 32'h0F, "int all");
    apb('1, 12'h300, 32'h01);
    // The write lands at the access edge; look once it has settled
    #1 `CHK("irq unmask", 1'h1, irq)
    apb('1, 12'h2F0, 32'h0F);
    #1 `CHK("irq clear", 1'h0, irq)
    `CHK("pulse count", 3, pulses)
    $display("test output done");
    complete_run;
  end
endmodule // testbench
`default_nettype wire
